// [hdl/pcs_clk_div.sv]
// Clock-output pin generator: toggles the pin at the system rate divided
// by 1, 2 or 4. Assumes the rate is given as num/(half?2:1) of clk_in.
`timescale 1ns/1ps
module pcs_clk_div (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    // Rate in, pin out
    pcs_div_if.gen   div
);
    logic [6:0] acc;
    wire  [6:0] thr  = (div.half ? 7'h02 : 7'h01) << div.odiv;
    wire  [6:0] step = {1'b0, div.num, 1'b0};
    wire  [6:0] sum  = acc + step;
    wire  [6:0] rem  = sum - thr;

    ////////////////////////////////////////////////////////////////////////
    // Half-period accumulator; faster than clk_in/2 saturates to a toggle
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            acc     <= 7'h00;
            div.pin <= 1'b0;
        end else if (ce_in) begin
            if (sum >= thr) begin
                div.pin <= ~div.pin;
                acc     <= (rem >= thr) ? 7'h00 : rem;
            end else begin
                acc <= sum;
            end
        end
    end
endmodule : pcs_clk_div

// [hdl/pcs_sequencer.sv]
// PLL clock-mode selection, reset sequencing and boot-pin sampling.
// Assumes clk_in is the input clock and the reset pin is pulled up on board.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Contract
// RULE1: Disable pin low at reset release: PLL off, system clock equals input clock.
// RULE2: Otherwise power-up mode is bypass: system clock is input clock divided by two.
// RULE3: Non-zero multiplier write enables PLL: system clock is input times n over two.
// RULE4: PLL locks within 131072 input cycles of enable or multiplier change.
// RULE5: Board supplies stable input clock 8 cycles before releasing reset.
// RULE6: Warm reset pin low pulse lasts at least 8 input cycles.
// RULE7: Watchdog reset drives the reset pin low for 512 input cycles.
// RULE8: External address and data become valid 32 cycles after reset release.
// RULE9: Disable pin stable 16 cycles before and after reset release.
// RULE10: Mode select pin stable 16 cycles after reset release.
// RULE11: Boot pins held 2520 input cycles after reset release.
// RULE12: Boot pins sampled after 1260 system cycles, then boot branches.
// RULE13: Config bits reset to one: clock pin shows system clock divided by four.
// RULE14: Full system clock rate reachable only with the PLL enabled.
// RULE15: Old rate kept until lock period ends, then new multiplied rate.
module pcs_sequencer
    import pcs_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = pcs_pkg::LOCK_CYC,
    parameter int unsigned BOOT_W      = 4
) (
    // Clock, reset, enable
    input  wire logic                clk_in,
    input  wire logic                arst_n_in,
    input  wire logic                ce_in,
    // APB slave
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [7:0]          paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output logic      [31:0]         prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    // Board pins
    input  wire logic                reset_pin_in,
    output logic                     reset_pin_out,
    output logic                     reset_pin_oe_out,
    input  wire logic                pll_disable_pin_in,
    input  wire logic                micro_mode_select_pin_in,
    input  wire logic [BOOT_W-1:0]   boot_mode_pin_in,
    output logic                     clock_output_pin_out,
    // Clock and boot status
    output logic [4:0]               sysclk_mult_out,
    output logic                     sysclk_half_out,
    output logic                     pll_off_out,
    output logic                     pll_locked_out,
    output logic                     max_rate_ok_out,
    output logic                     bus_valid_out,
    output logic                     boot_sampled_out,
    output logic [BOOT_W-1:0]        boot_mode_out,
    output logic                     micro_mode_out
);
    localparam int unsigned LCW = $clog2(LOCK_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [BOOT_W+2:0] sync1;
    logic [BOOT_W+2:0] sync2;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (ce_in) begin
            sync1 <= {boot_mode_pin_in, micro_mode_select_pin_in,
                      pll_disable_pin_in, reset_pin_in};
            sync2 <= sync1;
        end
    end
    wire              rst_pin_s = sync2[0];
    wire              dis_s     = sync2[1];
    wire              micro_s   = sync2[2];
    wire [BOOT_W-1:0] boot_s    = sync2[BOOT_W+2:3];
    wire              dev_rst   = !rst_pin_s;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    logic [MULT_W-1:0] mult_reg;
    logic [MULT_W-1:0] act_mult;
    logic [1:0]        cfg2;
    logic              locking;
    logic [LCW-1:0]    lock_cnt;
    logic              wd_active;
    logic [WD_W-1:0]   wd_cnt;
    pcs_state_t        state;
    logic [SEQ_W-1:0]  seq_cnt;

    wire setup    = psel_in && !penable_in;
    wire access   = psel_in && penable_in;
    wire hit_mult = pcs_hit(paddr_in, OFF_PLL_MULT);
    wire hit_cfg  = pcs_hit(paddr_in, OFF_EXT_CFG2);
    wire hit_stat = pcs_hit(paddr_in, OFF_STATUS);
    wire hit_wd   = pcs_hit(paddr_in, OFF_WDOG);
    wire mapped   = hit_mult || hit_cfg || hit_stat || hit_wd;
    wire wr_ok    = ce_in && access && pwrite_in && !dev_rst;
    wire wr_mult  = wr_ok && hit_mult && !pll_off_out && (state != PCS_HOLD);
    wire wr_cfg   = wr_ok && hit_cfg;
    wire wd_kick  = ce_in && access && pwrite_in && hit_wd && pwdata_in[WD_KICK_BIT];
    wire [MULT_W-1:0] wr_val = pwdata_in[MULT_W-1:0];

    wire [31:0] status_word = {{(16-BOOT_W){1'b0}}, boot_mode_out, 4'h0, act_mult,
                               1'b0, max_rate_ok_out, boot_sampled_out, bus_valid_out,
                               micro_mode_out, pll_off_out, locking, pll_locked_out};
    wire [31:0] rdata = hit_mult ? {{(32-MULT_W){1'b0}}, mult_reg}
                      : hit_cfg  ? {30'h0, cfg2}
                      : hit_stat ? status_word
                      : 32'h0000_0000;

    assign pready_out  = ce_in;
    assign pslverr_out = access && !mapped;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (ce_in && setup) begin
            prdata_out <= rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multiplier, lock timer and active rate
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mult_reg <= MULT_RST;
            act_mult <= MULT_RST;
            locking  <= 1'b0;
            lock_cnt <= '0;
        end else if (ce_in) begin
            if (dev_rst) begin
                mult_reg <= MULT_RST;
                act_mult <= MULT_RST;                                        // RULE2
                locking  <= 1'b0;
                lock_cnt <= '0;
            end else if (wr_mult) begin
                mult_reg <= wr_val;
                locking  <= (wr_val != '0);                                  // RULE3
                lock_cnt <= '0;
                if (wr_val == '0) begin
                    act_mult <= '0;
                end
            end else if (locking) begin
                lock_cnt <= lock_cnt + 1'b1;
                if (lock_cnt == LCW'(LOCK_CYCLES - 1)) begin                 // RULE4
                    act_mult <= mult_reg;                                    // RULE15
                    locking  <= 1'b0;
                end
            end
        end
    end

    assign pll_locked_out  = (act_mult != '0) && !locking;
    assign sysclk_mult_out = (act_mult == '0) ? 5'h01 : {1'b0, act_mult};    // RULE1 RULE3
    assign sysclk_half_out = !pll_off_out;                                   // RULE1 RULE2
    assign max_rate_ok_out = pll_locked_out &&                               // RULE14
        (64'(CLK_PERIOD_PS) * 64'd2 <= 64'(MAX_SYS_PERIOD_PS) * 64'(act_mult));

    ////////////////////////////////////////////////////////////////////////
    // External interface config and clock-output pin
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cfg2 <= CFG2_RST;
        end else if (ce_in) begin
            if (dev_rst) begin
                cfg2 <= CFG2_RST;                                            // RULE13
            end else if (wr_cfg) begin
                cfg2 <= pwdata_in[1:0];
            end
        end
    end

    pcs_div_if div_bus ();
    assign div_bus.num  = sysclk_mult_out;
    assign div_bus.half = sysclk_half_out;
    assign div_bus.odiv = 2'({1'b0, cfg2[CFG2_TIM_BIT]} + {1'b0, cfg2[CFG2_CLK_BIT]}); // RULE13
    assign clock_output_pin_out = div_bus.pin;

    pcs_clk_div u_div (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .ce_in     (ce_in),
        .div       (div_bus.gen)
    );

    ////////////////////////////////////////////////////////////////////////
    // Watchdog reset pulse on the open-drain reset pin
    assign reset_pin_out    = 1'b0;
    assign reset_pin_oe_out = wd_active;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wd_active <= 1'b0;
            wd_cnt    <= '0;
        end else if (ce_in) begin
            if (wd_active) begin
                wd_cnt <= wd_cnt + 1'b1;
                if (wd_cnt == WD_W'(WD_PULSE_CYC - 1)) begin                 // RULE7
                    wd_active <= 1'b0;
                end
            end else if (wd_kick) begin
                wd_active <= 1'b1;
                wd_cnt    <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release sequence: strap capture, bus valid, boot sampling
    wire [SEQ_W-1:0] boot_cyc = pll_off_out ? SEQ_W'(BOOT_SYS_CYC)
                                            : SEQ_W'(BOOT_SYS_CYC * 2);
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state            <= PCS_HOLD;
            seq_cnt          <= '0;
            pll_off_out      <= 1'b0;
            micro_mode_out   <= 1'b0;
            bus_valid_out    <= 1'b0;
            boot_sampled_out <= 1'b0;
            boot_mode_out    <= '0;
        end else if (ce_in) begin
            if (dev_rst) begin
                state            <= PCS_HOLD;
                seq_cnt          <= '0;
                bus_valid_out    <= 1'b0;
                boot_sampled_out <= 1'b0;
            end else begin
                case (state)
                    PCS_HOLD: begin
                        pll_off_out    <= !dis_s;                            // RULE1 RULE9
                        micro_mode_out <= micro_s;                           // RULE10
                        state          <= PCS_BOOT;
                    end
                    PCS_BOOT: begin
                        seq_cnt <= seq_cnt + 1'b1;
                        if (seq_cnt == SEQ_W'(BUS_VALID_CYC - 1)) begin
                            bus_valid_out <= 1'b1;                           // RULE8
                        end
                        if (seq_cnt == boot_cyc - 1'b1) begin
                            boot_mode_out    <= boot_s;                      // RULE12 RULE11
                            boot_sampled_out <= 1'b1;
                            state            <= PCS_RUN;
                        end
                    end
                    PCS_RUN: begin
                        state <= PCS_RUN;
                    end
                    default: begin
                        state <= PCS_HOLD;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [SEQ_W-1:0] rel_cnt;
    logic [WD_W:0]    oe_cnt;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rel_cnt <= '0;
            oe_cnt  <= '0;
        end else if (ce_in) begin
            rel_cnt <= dev_rst ? '0 : (rel_cnt + SEQ_W'(rel_cnt != '1));
            oe_cnt  <= reset_pin_oe_out ? oe_cnt + 1'b1 : '0;
        end
    end

    property p_pll_off;
        @(posedge clk_in) disable iff (!arst_n_in)
        pll_off_out |-> (sysclk_mult_out == 5'h01) && !sysclk_half_out && !locking;
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("PLL off mode rate wrong"); // RULE1

    property p_bypass;
        @(posedge clk_in) disable iff (!arst_n_in)
        (state == PCS_BOOT) && !pll_off_out |-> sysclk_half_out && sysclk_mult_out == 5'h01;
    endproperty
    a_bypass: assert property (p_bypass) else $error("Power-up not in bypass"); // RULE2

    property p_enable;
        @(posedge clk_in) disable iff (!arst_n_in)
        wr_mult && (wr_val != '0) |=> locking && lock_cnt == '0;
    endproperty
    a_enable: assert property (p_enable) else $error("Multiplier write did not start PLL"); // RULE3

    property p_lock;
        @(posedge clk_in) disable iff (!arst_n_in)
        locking |-> lock_cnt < LCW'(LOCK_CYCLES);
    endproperty
    a_lock: assert property (p_lock) else $error("Lock exceeded limit"); // RULE4

    property p_wd;
        @(posedge clk_in) disable iff (!arst_n_in)
        $fell(reset_pin_oe_out) |-> $past(oe_cnt) == (WD_W + 1)'(WD_PULSE_CYC - 1);
    endproperty
    a_wd: assert property (p_wd) else $error("Watchdog pulse length wrong"); // RULE7

    property p_busval;
        @(posedge clk_in) disable iff (!arst_n_in)
        $rose(bus_valid_out) |-> rel_cnt == SEQ_W'(BUS_VALID_CYC + 1);
    endproperty
    a_busval: assert property (p_busval) else $error("Bus valid delay wrong"); // RULE8

    property p_boot;
        @(posedge clk_in) disable iff (!arst_n_in)
        $rose(boot_sampled_out) |-> rel_cnt == boot_cyc + 1'b1 && boot_mode_out == $past(boot_s);
    endproperty
    a_boot: assert property (p_boot) else $error("Boot sample moment wrong"); // RULE12

    property p_cfg;
        @(posedge clk_in) disable iff (!arst_n_in)
        ce_in && dev_rst |=> div_bus.odiv == 2'h2;
    endproperty
    a_cfg: assert property (p_cfg) else $error("Clock pin not divided by four"); // RULE13

    property p_max;
        @(posedge clk_in) disable iff (!arst_n_in)
        max_rate_ok_out |-> sysclk_half_out && act_mult >= MULT_W'(8) && !locking;
    endproperty
    a_max: assert property (p_max) else $error("Max rate without PLL"); // RULE14

    property p_hold_rate;
        @(posedge clk_in) disable iff (!arst_n_in)
        ce_in && locking && !wr_mult && !dev_rst && lock_cnt != LCW'(LOCK_CYCLES - 1)
            |=> $stable(act_mult);
    endproperty
    a_hold_rate: assert property (p_hold_rate) else $error("Rate changed during lock"); // RULE15

endmodule : pcs_sequencer

// [include/pcs_div_if.sv]
// Carrier between the sequencer and the clock-output divider.
// Assumes both ends run on the same input clock.
`timescale 1ns/1ps
interface pcs_div_if;
    logic [4:0] num;
    logic       half;
    logic [1:0] odiv;
    logic       pin;
    modport ctl (output num, output half, output odiv, input pin);
    modport gen (input num, input half, input odiv, output pin);
endinterface : pcs_div_if

// [include/pcs_pkg.sv]
// Constants, types and helpers of the PLL clock and reset sequencer.
// Assumes a single 40 MHz input clock and an APB register port.
package pcs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clocking figures
    localparam int unsigned CLK_PERIOD_PS     = 25000;
    localparam int unsigned MAX_SYS_PERIOD_PS = 6670;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_PLL_MULT = 8'h00;
    localparam logic [7:0] OFF_EXT_CFG2 = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_WDOG     = 8'h0C;

    ////////////////////////////////////////////////////////////////////////
    // Fields and reset values
    localparam int unsigned MULT_W         = 4;
    localparam logic [3:0]  MULT_RST       = 4'h0;
    localparam int unsigned CFG2_TIM_BIT   = 0;
    localparam int unsigned CFG2_CLK_BIT   = 1;
    localparam logic [1:0]  CFG2_RST       = 2'h3;
    localparam int unsigned WD_KICK_BIT    = 0;
    localparam int unsigned ST_LOCKED_BIT  = 0;
    localparam int unsigned ST_LOCKING_BIT = 1;
    localparam int unsigned ST_PLL_OFF_BIT = 2;
    localparam int unsigned ST_MICRO_BIT   = 3;
    localparam int unsigned ST_BUSVAL_BIT  = 4;
    localparam int unsigned ST_BOOTED_BIT  = 5;
    localparam int unsigned ST_MAXRATE_BIT = 6;
    localparam int unsigned ST_MULT_LSB    = 8;
    localparam int unsigned ST_BOOT_LSB    = 16;

    ////////////////////////////////////////////////////////////////////////
    // Timing counts in input-clock cycles, boot delay in system cycles, counter widths
    localparam int unsigned LOCK_CYC      = 131072;
    localparam int unsigned WD_PULSE_CYC  = 512;
    localparam int unsigned BUS_VALID_CYC = 32;
    localparam int unsigned BOOT_SYS_CYC  = 1260;
    localparam int unsigned SEQ_W         = 12;
    localparam int unsigned WD_W          = 10;

    typedef enum logic [2:0] {
        PCS_HOLD = 3'b001,
        PCS_BOOT = 3'b010,
        PCS_RUN  = 3'b100
    } pcs_state_t;

    function automatic logic pcs_hit(input logic [7:0] addr, input logic [7:0] off);
        pcs_hit = (addr[7:2] == off[7:2]);
    endfunction : pcs_hit

endpackage : pcs_pkg

// [testbench/pcs_board.sv]
// Board model: pulled-up reset pin, warm reset source and strap pins.
// Assumes the device pulls the reset pin only while its enable is high.
`timescale 1ns/1ps
module pcs_board (
    // Clock and device side
    input  wire logic       clk_in,
    input  wire logic       reset_pin_oe_in,
    input  wire logic       reset_pin_drv_in,
    // Board pins
    output logic            reset_pin_out,
    output logic            pll_disable_pin_out,
    output logic            micro_mode_select_pin_out,
    output logic [3:0]      boot_mode_pin_out
);
    logic hold_low = 1'b1;

    // Pull-up unless the board or the device pulls low
    assign reset_pin_out = reset_pin_oe_in ? reset_pin_drv_in : !hold_low;

    initial begin
        pll_disable_pin_out       = 1'b1;
        micro_mode_select_pin_out = 1'b1;
        boot_mode_pin_out         = 4'hA;
    end

    ////////////////////////////////////////////////////////////////////////
    // Straps move only inside reset and stand until the next press
    task automatic press(input int n, input logic dis, input logic mm, input logic [3:0] bm);
        @(posedge clk_in);
        hold_low <= 1'b1;
        repeat (4) @(posedge clk_in);
        pll_disable_pin_out       <= dis;
        micro_mode_select_pin_out <= mm;
        boot_mode_pin_out         <= bm;
        repeat (n) @(posedge clk_in);
        hold_low <= 1'b0;
    endtask : press
endmodule : pcs_board

// [testbench/test_pll_clock_reset_sequencer.sv]
// Self-checking bench of the PLL clock and reset sequencer.
// Assumes pcs_pkg, pcs_div_if and the design files are compiled first.
`timescale 1ns/1ps
module test_pll_clock_reset_sequencer;
    import pcs_pkg::*;
    localparam int LOCKN = 16;
    logic clk_in = 1'b0;
    logic arst_n_in, ce_in, psel_in, penable_in, pwrite_in;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in, prdata_out, q;
    logic pready_out, pslverr_out, reset_pin, reset_pin_out, reset_pin_oe_out;
    logic pll_dis, micro_pin, clock_output_pin_out, sysclk_half_out, pll_off_out;
    logic pll_locked_out, max_rate_ok_out, bus_valid_out, boot_sampled_out, micro_mode_out;
    logic [3:0]  boot_pins, boot_mode_out;
    logic [4:0]  sysclk_mult_out;
    logic        err;
    int n_fail = 0;
    int compares = 0;
    int n, m;

    always #12.5 clk_in = ~clk_in;

    pcs_board board (.clk_in(clk_in), .reset_pin_oe_in(reset_pin_oe_out),
        .reset_pin_drv_in(reset_pin_out), .reset_pin_out(reset_pin),
        .pll_disable_pin_out(pll_dis), .micro_mode_select_pin_out(micro_pin),
        .boot_mode_pin_out(boot_pins));

    pcs_sequencer #(.LOCK_CYCLES(LOCKN), .BOOT_W(4)) DUT (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .reset_pin_in(reset_pin), .reset_pin_out(reset_pin_out),
        .reset_pin_oe_out(reset_pin_oe_out), .pll_disable_pin_in(pll_dis),
        .micro_mode_select_pin_in(micro_pin), .boot_mode_pin_in(boot_pins),
        .clock_output_pin_out(clock_output_pin_out), .sysclk_mult_out(sysclk_mult_out),
        .sysclk_half_out(sysclk_half_out), .pll_off_out(pll_off_out),
        .pll_locked_out(pll_locked_out), .max_rate_ok_out(max_rate_ok_out),
        .bus_valid_out(bus_valid_out), .boot_sampled_out(boot_sampled_out),
        .boot_mode_out(boot_mode_out), .micro_mode_out(micro_mode_out));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic rng(input string name, input int lo, input int hi, input int v);
        compares++;
        if (v < lo || v > hi) begin
            n_fail++;
            $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, v);
        end
    endtask : rng

    function automatic logic flag(input int w);
        case (w)
            0: flag = bus_valid_out;
            1: flag = boot_sampled_out;
            2: flag = pll_locked_out;
            3: flag = reset_pin_oe_out;
            default: flag = !reset_pin_oe_out;
        endcase
    endfunction : flag

    // Counts edges until the flag is seen set; a spent bound ends the run
    task automatic wait_flag(input int w, input int lim, output int k);
        k = 0;
        while (flag(w) !== 1'b1) begin
            @(posedge clk_in);
            k++;
            if (k > lim) begin
                n_fail++;
                $display("ERROR wait flag %0d expected 1 seen 0", w);
                stop_test();
            end
        end
    endtask : wait_flag

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_in);
        psel_in    <= 1'b1;
        pwrite_in  <= wr;
        paddr_in   <= a;
        pwdata_in  <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_in);
            if (pready_out === 1'b1) break;
        end
        if (i == 50) begin
            n_fail++;
            $display("ERROR pready expected 1 seen 0");
            stop_test();
        end
        q   = prdata_out;
        err = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    // Edges between two toggles of the clock output pin
    task automatic half_period(output int k);
        logic v;
        int j;
        @(posedge clk_in);
        v = clock_output_pin_out;
        j = 0;
        while (clock_output_pin_out === v && j < 40) begin
            @(posedge clk_in);
            j++;
        end
        v = clock_output_pin_out;
        k = 0;
        while (clock_output_pin_out === v && k < 40) begin
            @(posedge clk_in);
            k++;
        end
    endtask : half_period

    ////////////////////////////////////////////////////////////////////////
    task automatic s_powerup();
        wait_flag(0, 60, n);
        rng("bus valid delay", 33, 38, n);
        chk("mult", 5'h01, sysclk_mult_out);
        chk("half", 1'b1, sysclk_half_out);
        chk("pll off", 1'b0, pll_off_out);
        chk("max rate", 1'b0, max_rate_ok_out);
        wait_flag(1, 3000, m);
        rng("boot delay", 2520, 2528, n + m);
        chk("boot mode", 4'hA, boot_mode_out);
        chk("micro", 1'b1, micro_mode_out);
        half_period(m);
        rng("clock pin half", 4, 4, m);
        apb(1'b0, OFF_EXT_CFG2, 32'h0);
        chk("cfg2", 32'h3, q);
        apb(1'b1, OFF_EXT_CFG2, 32'h0);
        half_period(m);
        rng("clock pin half", 1, 1, m);
        apb(1'b1, OFF_EXT_CFG2, 32'h3);
    endtask : s_powerup

    task automatic s_pll(input logic [3:0] mv, input logic fast);
        apb(1'b1, OFF_PLL_MULT, {28'h0, mv});
        repeat (2) @(posedge clk_in);
        chk("locked", 1'b0, pll_locked_out);
        wait_flag(2, LOCKN + 6, n);
        rng("lock time", LOCKN - 2, LOCKN + 3, n);
        chk("mult", {1'b0, mv}, sysclk_mult_out);
        chk("half", 1'b1, sysclk_half_out);
        chk("max rate", fast, max_rate_ok_out);
    endtask : s_pll

    task automatic s_regs();
        apb(1'b1, OFF_PLL_MULT, 32'h9);
        repeat (2) @(posedge clk_in);
        chk("old mult", 5'h05, sysclk_mult_out);
        wait_flag(2, LOCKN + 6, n);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", 32'h949, q & 32'hF4F);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0, q);
        ce_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk("ce low ready", 1'b0, pready_out);
        chk("ce low mult", 5'h09, sysclk_mult_out);
        ce_in <= 1'b1;
        apb(1'b1, OFF_PLL_MULT, 32'h0);
        @(posedge clk_in);
        chk("bypass mult", 5'h01, sysclk_mult_out);
    endtask : s_regs

    task automatic s_disabled();
        board.press(20, 1'b0, 1'b0, 4'h5);
        wait_flag(0, 60, n);
        wait_flag(1, 2000, m);
        rng("boot delay", 1260, 1268, n + m);
        chk("boot mode", 4'h5, boot_mode_out);
        chk("pll off", 1'b1, pll_off_out);
        chk("mult", 5'h01, sysclk_mult_out);
        chk("half", 1'b0, sysclk_half_out);
        apb(1'b1, OFF_PLL_MULT, 32'h9);
        repeat (LOCKN + 4) @(posedge clk_in);
        chk("ignored mult", 5'h01, sysclk_mult_out);
        chk("max rate", 1'b0, max_rate_ok_out);
        board.press(20, 1'b1, 1'b1, 4'h3);
        wait_flag(0, 60, n);
    endtask : s_disabled

    task automatic s_watchdog();
        apb(1'b1, OFF_WDOG, 32'h1);
        wait_flag(3, 4, n);
        wait_flag(4, 600, n);
        rng("watchdog pulse", 512, 512, n);
        wait_flag(0, 60, n);
        rng("bus valid delay", 33, 38, n);
        chk("mult after reset", 5'h01, sysclk_mult_out);
    endtask : s_watchdog

    ////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n_in  = 1'b0;
        ce_in      = 1'b1;
        psel_in    = 1'b0;
        penable_in = 1'b0;
        pwrite_in  = 1'b0;
        paddr_in   = 8'h00;
        pwdata_in  = 32'h0;
        repeat (8) @(posedge clk_in);
        arst_n_in <= 1'b1;
        board.press(20, 1'b1, 1'b1, 4'hA);
        s_powerup();
        s_pll(4'h5, 1'b0);
        s_regs();
        s_pll(4'h9, 1'b1);
        s_disabled();
        s_watchdog();
        stop_test();
    end
endmodule : test_pll_clock_reset_sequencer
